// *** crpc_ctrl.v ***
// Operation
// - Pulling the hard reset pin low holds the device in full reset until the stretch count runs out after the pin returns high.
// - A soft reset command taken from the serial interface resets the device with no reset pin.
// - An internal power-on reset resets the logic at power-up regardless of the reset pin.
// - In reset the serial data, flash, video and general pins float; pin one floats always.
// - In default and standby states flash clock and data drive low, chip select high, pull-up on.
// - After reset general pins five to two are sampled as straps, then released until firmware.
// - Video outputs drive a configured default in the default state; in the standby, stream and idle states they are driven only when used.
`timescale 1ns/1ps
`default_nettype none
`include "crpc_regs.vh"
module crpc_ctrl #(
    parameter VIDEO_W = 16,
    parameter [VIDEO_W-1:0] VIDEO_DEFAULT = 16'h0000
) (
    input wire clock,
    input wire nrst,
    input wire reset_pin_n,
    input wire por_n,
    input wire soft_reset_cmd,
    input wire standby_pin,
    input wire [1:0] fw_mode,
    input wire video_used,
    input wire [3:0] gpio_fw_oe,
    input wire [3:0] gpio_fw_out,
    input wire [3:0] gpio_pin_in,
    input wire flash_clk_fw,
    input wire flash_do_fw,
    input wire flash_cs_n_fw,
    input wire serial_data_fw_oe,
    input wire frame_valid_fw,
    input wire line_valid_fw,
    input wire pixel_clock_fw,
    input wire [VIDEO_W-1:0] video_data_fw,
    output reg core_reset_n,
    output reg [2:0] pin_state,
    output reg [3:0] strap_value,
    output reg strap_valid,
    output reg serial_data_oe,
    output reg flash_clk_out,
    output reg flash_clk_oe,
    output reg flash_data_out,
    output reg flash_data_oe,
    output reg flash_cs_n_out,
    output reg flash_cs_n_oe,
    output wire flash_data_in_pullup,
    output reg frame_valid_out,
    output reg line_valid_out,
    output reg pixel_clock_out,
    output reg [VIDEO_W-1:0] video_data_out,
    output reg video_oe,
    output reg [3:0] gpio_out,
    output reg [3:0] gpio_oe,
    output wire general_pin_one_out,
    output wire general_pin_one_oe
);
    wire reset_pin_s;
    wire standby_s;
    wire [3:0] gpio_s;
    reg [7:0] por_cnt_q;
    reg [7:0] por_cnt_d;
    reg rst_hold_q;
    reg [3:0] strap_cnt_q;
    reg [2:0] state_q;
    reg [2:0] state_d;

    // Pins come from outside the clock domain
    crpc_sync #(.WIDTH(6)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in({reset_pin_n, standby_pin, gpio_pin_in}),
        .sync_out({reset_pin_s, standby_s, gpio_s})
    );

    // Any of the three sources restarts the reset stretch
    always @*
    begin
        por_cnt_d = por_cnt_q;
        if (!reset_pin_s || soft_reset_cmd)
            por_cnt_d = `CRPC_POR_CYCLES;
        else if (por_cnt_q != 8'h00)
            por_cnt_d = por_cnt_q - 8'h01;
    end

    // Stretch counter loads full on power-on reset
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            por_cnt_q <= `CRPC_POR_CYCLES;
            rst_hold_q <= 1'b1;
        end
        else if (!por_n)
        begin
            por_cnt_q <= `CRPC_POR_CYCLES;
            rst_hold_q <= 1'b1;
        end
        else
        begin
            por_cnt_q <= por_cnt_d;
            rst_hold_q <= (por_cnt_d != 8'h00);
        end
    end

    // Pin-state sequencing; standby pin wins over firmware modes
    always @*
    begin
        state_d = state_q;
        case (state_q)
            `CRPC_ST_RESET:
                state_d = `CRPC_ST_STRAP;
            `CRPC_ST_STRAP:
                if (strap_cnt_q == `CRPC_STRAP_CYCLES)
                    state_d = `CRPC_ST_DEFAULT;
            default:
            begin
                if (standby_s)
                    state_d = `CRPC_ST_HSTBY;
                else if (fw_mode == `CRPC_FW_SSTBY)
                    state_d = `CRPC_ST_SSTBY;
                else if (fw_mode == `CRPC_FW_STREAM)
                    state_d = `CRPC_ST_STREAM;
                else if (fw_mode == `CRPC_FW_IDLE)
                    state_d = `CRPC_ST_IDLE;
                else
                    state_d = `CRPC_ST_DEFAULT;
            end
        endcase
    end

    // State, strap capture and reset output
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= `CRPC_ST_RESET;
            strap_cnt_q <= 4'h0;
            strap_value <= 4'h0;
            strap_valid <= 1'b0;
            core_reset_n <= 1'b0;
            pin_state <= `CRPC_ST_RESET;
        end
        else if (rst_hold_q)
        begin
            state_q <= `CRPC_ST_RESET;
            strap_cnt_q <= 4'h0;
            strap_valid <= 1'b0;
            core_reset_n <= 1'b0;
            pin_state <= `CRPC_ST_RESET;
        end
        else
        begin
            state_q <= state_d;
            pin_state <= state_d;
            core_reset_n <= 1'b1;
            if (state_q == `CRPC_ST_STRAP)
            begin
                strap_cnt_q <= strap_cnt_q + 4'h1;
                // Last sample taken just before release
                if (strap_cnt_q == `CRPC_STRAP_CYCLES)
                begin
                    strap_value <= gpio_s;
                    strap_valid <= 1'b1;
                end
            end
        end
    end

    // Reset overrides the next state, so pads float on the edge core reset falls
    wire [2:0] drive_state;
    assign drive_state = rst_hold_q ? `CRPC_ST_RESET : state_d;

    // Output drive per pin state; registered so pads never glitch
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_data_oe <= 1'b0;
            flash_clk_out <= 1'b0;
            flash_clk_oe <= 1'b0;
            flash_data_out <= 1'b0;
            flash_data_oe <= 1'b0;
            flash_cs_n_out <= 1'b0;
            flash_cs_n_oe <= 1'b0;
            frame_valid_out <= 1'b0;
            line_valid_out <= 1'b0;
            pixel_clock_out <= 1'b0;
            video_data_out <= {VIDEO_W{1'b0}};
            video_oe <= 1'b0;
            gpio_out <= 4'h0;
            gpio_oe <= 4'h0;
        end
        else
        begin
            case (drive_state)
                `CRPC_ST_RESET, `CRPC_ST_STRAP:
                begin
                    // All floating while reset or strap sampling
                    serial_data_oe <= 1'b0;
                    flash_clk_oe <= 1'b0;
                    flash_data_oe <= 1'b0;
                    flash_cs_n_oe <= 1'b0;
                    video_oe <= 1'b0;
                    gpio_oe <= 4'h0;
                    flash_clk_out <= 1'b0;
                    flash_data_out <= 1'b0;
                    flash_cs_n_out <= 1'b0;
                    frame_valid_out <= 1'b0;
                    line_valid_out <= 1'b0;
                    pixel_clock_out <= 1'b0;
                    video_data_out <= {VIDEO_W{1'b0}};
                    gpio_out <= 4'h0;
                end
                `CRPC_ST_STREAM, `CRPC_ST_IDLE:
                begin
                    // Firmware owns the flash and serial pins here
                    serial_data_oe <= serial_data_fw_oe;
                    flash_clk_out <= flash_clk_fw;
                    flash_data_out <= flash_do_fw;
                    flash_cs_n_out <= flash_cs_n_fw;
                    flash_clk_oe <= 1'b1;
                    flash_data_oe <= 1'b1;
                    flash_cs_n_oe <= 1'b1;
                    video_oe <= video_used;
                    frame_valid_out <= frame_valid_fw;
                    line_valid_out <= line_valid_fw;
                    pixel_clock_out <= pixel_clock_fw;
                    video_data_out <= video_data_fw;
                    gpio_oe <= gpio_fw_oe;
                    gpio_out <= gpio_fw_out;
                end
                default:
                begin
                    // Default and both standby states
                    serial_data_oe <= 1'b0;
                    flash_clk_out <= `CRPC_FLASH_CLK_IDLE;
                    flash_data_out <= `CRPC_FLASH_DO_IDLE;
                    flash_cs_n_out <= `CRPC_FLASH_CS_IDLE;
                    flash_clk_oe <= 1'b1;
                    flash_data_oe <= 1'b1;
                    flash_cs_n_oe <= 1'b1;
                    if (drive_state == `CRPC_ST_DEFAULT)
                    begin
                        // Configured default level, driven once strap sampling ends
                        video_oe <= 1'b1;
                        frame_valid_out <= 1'b0;
                        line_valid_out <= 1'b0;
                        pixel_clock_out <= 1'b0;
                        video_data_out <= VIDEO_DEFAULT;
                        gpio_oe <= 4'h0;
                        gpio_out <= 4'h0;
                    end
                    else
                    begin
                        video_oe <= video_used;
                        frame_valid_out <= frame_valid_fw;
                        line_valid_out <= line_valid_fw;
                        pixel_clock_out <= pixel_clock_fw;
                        video_data_out <= video_data_fw;
                        gpio_oe <= gpio_fw_oe;
                        gpio_out <= gpio_fw_out;
                    end
                end
            endcase
        end
    end

    // Pull-up never switched off; pin one never driven
    assign flash_data_in_pullup = 1'b1;
    assign general_pin_one_out = 1'b0;
    assign general_pin_one_oe = 1'b0;
endmodule // crpc_ctrl
`default_nettype wire

// *** crpc_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crpc_regs.vh"
module crpc_ctrl_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire logic reset_pin_n,
    input wire logic por_n,
    input wire logic soft_reset_cmd,
    input wire logic video_used,
    input wire logic core_reset_n,
    input wire logic [2:0] pin_state,
    input wire logic strap_valid,
    input wire logic serial_data_oe,
    input wire logic flash_clk_out,
    input wire logic flash_clk_oe,
    input wire logic flash_data_out,
    input wire logic flash_data_oe,
    input wire logic flash_cs_n_out,
    input wire logic flash_cs_n_oe,
    input wire logic flash_data_in_pullup,
    input wire logic video_oe,
    input wire logic [3:0] gpio_oe,
    input wire logic general_pin_one_oe
);
    // Any pin driver other than general pin one, and the states where the flash pins idle
    wire any_oe = serial_data_oe | flash_clk_oe | flash_data_oe | flash_cs_n_oe | video_oe
        | (|gpio_oe);
    wire quiet = pin_state == `CRPC_ST_DEFAULT || pin_state == `CRPC_ST_HSTBY
        || pin_state == `CRPC_ST_SSTBY;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Pads float on the very edge that core reset falls
    a_reset_floats: assert property (!core_reset_n |-> !any_oe)
        else $error("pin driven while in reset");
    a_pin_one_float: assert property (!general_pin_one_oe)
        else $error("general pin one driven");
    a_pullup_on: assert property (flash_data_in_pullup)
        else $error("flash input pull-up off");
    a_flash_idle: assert property (quiet && $stable(pin_state) |->
        !flash_clk_out && !flash_data_out && flash_cs_n_out && flash_clk_oe && flash_data_oe
        && flash_cs_n_oe)
        else $error("flash pins not at idle levels");
    a_hard_enter: assert property (!reset_pin_n |-> ##[1:4] !core_reset_n)
        else $error("hard reset not taken");
    a_soft_enter: assert property (soft_reset_cmd |-> ##[1:3] !core_reset_n)
        else $error("soft reset not taken");
    a_por_enter: assert property (!por_n |-> ##[1:3] !core_reset_n)
        else $error("power-on reset not taken");
    a_strap_float: assert property (pin_state == `CRPC_ST_STRAP |-> gpio_oe == 4'h0)
        else $error("general pins driven while sampling");
    a_strap_done: assert property ($past(pin_state) == `CRPC_ST_STRAP && quiet
        |-> ##[0:1] strap_valid)
        else $error("straps not valid after sampling");
    a_video_unused: assert property (pin_state >= `CRPC_ST_HSTBY && $stable(pin_state)
        && !video_used && !$past(video_used) |-> !video_oe)
        else $error("unused video outputs driven");
    c_strap: cover property ($rose(strap_valid));
    c_stream: cover property (pin_state == `CRPC_ST_STREAM && video_oe);
    c_hstby: cover property (pin_state == `CRPC_ST_HSTBY);
endmodule // crpc_ctrl_asserts
bind crpc_ctrl crpc_ctrl_asserts crpc_ctrl_asserts_i (.clock, .nrst, .reset_pin_n, .por_n,
    .soft_reset_cmd, .video_used, .core_reset_n, .pin_state, .strap_valid, .serial_data_oe,
    .flash_clk_out, .flash_clk_oe, .flash_data_out, .flash_data_oe, .flash_cs_n_out,
    .flash_cs_n_oe, .flash_data_in_pullup, .video_oe, .gpio_oe, .general_pin_one_oe);
`default_nettype wire

// *** crpc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module crpc_host_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hard_req,
    input wire logic stby_req,
    input wire logic soft_req,
    input wire logic [3:0] strap_drive,
    output logic reset_pin_n,
    output logic standby_pin,
    output logic soft_reset_cmd,
    output logic [3:0] gpio_pin_in
);
    logic [7:0] boot_q;
    // Every pin leaves reset at a defined level; serial access waits out the wake-up
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            boot_q <= 8'h00;
            reset_pin_n <= 1'b1;
            standby_pin <= 1'b0;
            soft_reset_cmd <= 1'b0;
            gpio_pin_in <= 4'h0;
        end
        else
        begin
            if (boot_q < 8'h64)
                boot_q <= boot_q + 8'h01;
            reset_pin_n <= !hard_req;
            standby_pin <= stby_req;
            soft_reset_cmd <= soft_req && boot_q >= 8'h64;
            gpio_pin_in <= strap_drive;
        end
    end
endmodule // crpc_host_model
`default_nettype wire

// *** crpc_regs.vh ***
`ifndef CRPC_REGS_VH
`define CRPC_REGS_VH
// Power-on reset stretch, in clock cycles
`define CRPC_POR_CYCLES 8'h10
// Strap counter value that ends sampling; the strap state lasts this many cycles plus one
`define CRPC_STRAP_CYCLES 4'h4
// Serial-flash idle levels
`define CRPC_FLASH_CLK_IDLE 1'h0
`define CRPC_FLASH_DO_IDLE 1'h0
`define CRPC_FLASH_CS_IDLE 1'h1
// Pin-state codes
`define CRPC_ST_RESET 3'h0
`define CRPC_ST_STRAP 3'h1
`define CRPC_ST_DEFAULT 3'h2
`define CRPC_ST_HSTBY 3'h3
`define CRPC_ST_SSTBY 3'h4
`define CRPC_ST_STREAM 3'h5
`define CRPC_ST_IDLE 3'h6
// Firmware mode request codes
`define CRPC_FW_DEFAULT 2'h0
`define CRPC_FW_SSTBY 2'h1
`define CRPC_FW_STREAM 2'h2
`define CRPC_FW_IDLE 2'h3
`endif

// *** crpc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module crpc_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire nrst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // Two stages; first stage feeds only the second
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // crpc_sync
`default_nettype wire

// *** test_camera_reset_pin_state_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crpc_regs.vh"
module test_camera_reset_pin_state_control;
    logic clock = 0, nrst = 0, por_n = 1, video_used = 0, hard_req = 0, stby_req = 0, soft_req = 0;
    logic flash_clk_fw = 0, flash_do_fw = 0, flash_cs_n_fw = 0, serial_data_fw_oe = 0;
    logic frame_valid_fw = 0, line_valid_fw = 0, pixel_clock_fw = 0;
    logic [1:0] fw_mode = 0;
    logic [3:0] gpio_fw_oe = 0, gpio_fw_out = 0, strap = 4'ha;
    logic [15:0] video_data_fw = 0;
    logic reset_pin_n, standby_pin, soft_reset_cmd, core_reset_n, strap_valid, video_oe;
    logic flash_clk_out, flash_data_out, flash_cs_n_out;
    logic [2:0] pin_state, want;
    logic [3:0] gpio_pin_in, strap_value, gpio_oe;
    logic [15:0] video_data_out;
    logic serial_data_oe, frame_valid_out, line_valid_out, pixel_clock_out;
    logic [3:0] gpio_out;
    // Drive level the controller uses in its default state
    localparam logic [15:0] video_def = 16'h0000;
    integer seed = 21437, failures = 0, checks_done = 0, cycles = 0, i;
    crpc_host_model crpc_host_model_i (.clock, .nrst, .hard_req, .stby_req, .soft_req,
        .strap_drive(strap), .reset_pin_n, .standby_pin, .soft_reset_cmd, .gpio_pin_in);
    crpc_ctrl crpc_ctrl_i (.clock, .nrst, .reset_pin_n, .por_n, .soft_reset_cmd, .standby_pin,
        .fw_mode, .video_used, .gpio_fw_oe, .gpio_fw_out, .gpio_pin_in, .flash_clk_fw,
        .flash_do_fw, .flash_cs_n_fw, .serial_data_fw_oe, .frame_valid_fw, .line_valid_fw,
        .pixel_clock_fw, .video_data_fw, .core_reset_n, .pin_state, .strap_value, .strap_valid,
        .serial_data_oe, .flash_clk_out, .flash_clk_oe(), .flash_data_out, .flash_data_oe(),
        .flash_cs_n_out, .flash_cs_n_oe(), .flash_data_in_pullup(), .frame_valid_out,
        .line_valid_out, .pixel_clock_out, .video_data_out, .video_oe, .gpio_out, .gpio_oe,
        .general_pin_one_out(), .general_pin_one_oe());
    // 100 MHz clock and a hang limit well past the expected run
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            failures = failures + 1;
            close_out;
        end
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait, sampled on the falling edge where outputs have settled
    task wait_state(input logic [2:0] s);
        integer n;
        n = 0;
        while (pin_state !== s && n < 60)
        begin
            @(negedge clock);
            n = n + 1;
        end
        check(pin_state, s);
    endtask
    // Standby wins over the firmware mode
    function logic [2:0] exp_state(input logic stby, input logic [1:0] m);
        if (stby)
            return `CRPC_ST_HSTBY;
        case (m)
            `CRPC_FW_DEFAULT: return `CRPC_ST_DEFAULT;
            `CRPC_FW_SSTBY: return `CRPC_ST_SSTBY;
            `CRPC_FW_STREAM: return `CRPC_ST_STREAM;
            default: return `CRPC_ST_IDLE;
        endcase
    endfunction
    // Firmware owns the flash and serial pins only while streaming or idle
    function logic fw_owned(input logic [2:0] s);
        return s == `CRPC_ST_STREAM || s == `CRPC_ST_IDLE;
    endfunction
    // Flash pins sit at idle levels in default and both standby states
    function logic [2:0] exp_flash(input logic [2:0] s);
        if (fw_owned(s))
            return {flash_clk_fw, flash_do_fw, flash_cs_n_fw};
        return {`CRPC_FLASH_CLK_IDLE, `CRPC_FLASH_DO_IDLE, `CRPC_FLASH_CS_IDLE};
    endfunction
    // Power-up, random mode walk, then each reset cause in turn
    initial
    begin
        repeat (4) @(posedge clock);
        nrst <= 1;
        wait_state(`CRPC_ST_DEFAULT);
        check(strap_value, strap);
        check(strap_valid, 1'b1);
        check({flash_clk_out, flash_data_out, flash_cs_n_out}, 3'h1);
        check(gpio_oe, 4'h0);
        for (i = 0; i < 27; i = i + 1)
        begin
            @(posedge clock);
            fw_mode <= (i < 4) ? i[1:0] : $random(seed);
            stby_req <= (i % 6 == 5);
            {video_used, gpio_fw_oe, gpio_fw_out, flash_clk_fw, flash_do_fw, flash_cs_n_fw,
                serial_data_fw_oe, frame_valid_fw, line_valid_fw, pixel_clock_fw,
                video_data_fw} <= $random(seed);
            repeat (8) @(negedge clock);
            want = exp_state(stby_req, fw_mode);
            check(pin_state, want);
            check(video_oe, want == `CRPC_ST_DEFAULT ? 1'b1 : video_used);
            check({flash_clk_out, flash_data_out, flash_cs_n_out}, exp_flash(want));
            check(serial_data_oe, fw_owned(want) & serial_data_fw_oe);
            if (want == `CRPC_ST_DEFAULT)
            begin
                check(gpio_oe, 4'h0);
                check(video_data_out, video_def);
            end
            else
            begin
                check(gpio_oe, gpio_fw_oe);
                check(gpio_out, gpio_fw_out);
                if (video_used)
                begin
                    check(video_data_out, video_data_fw);
                    check({frame_valid_out, line_valid_out, pixel_clock_out},
                        {frame_valid_fw, line_valid_fw, pixel_clock_fw});
                end
            end
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            @(posedge clock);
            stby_req <= 0;
            fw_mode <= `CRPC_FW_STREAM;
            strap <= $random(seed);
            hard_req <= (i == 0);
            soft_req <= (i == 1);
            por_n <= (i != 2);
            repeat (6) @(negedge clock);
            check(core_reset_n, 1'b0);
            check(pin_state, `CRPC_ST_RESET);
            check({video_oe, gpio_oe, serial_data_oe, strap_valid}, 7'h00);
            @(posedge clock);
            {hard_req, soft_req, por_n} <= 3'h1;
            wait_state(`CRPC_ST_STREAM);
            check(strap_value, strap);
        end
        close_out;
    end
endmodule // test_camera_reset_pin_state_control
`default_nettype wire
